// ===== rtl/cst_pkg.sv
package cst_pkg;
  // APB register offsets.
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_SPAN   = 8'h04;
  localparam logic [7:0] REG_ERASE  = 8'h08;
  localparam logic [7:0] REG_VAR    = 8'h0c;
  localparam logic [7:0] REG_STAT   = 8'h10;
  localparam logic [7:0] REG_LIVE   = 8'h14;
  // Field positions in REG_CFG and REG_ERASE.
  localparam int CFG_SEC = 2;
  localparam int CFG_SPD = 8;
  localparam int CFG_PM  = 16;
  localparam int CFG_AU  = 24;
  localparam int ER_TO   = 16;
  localparam int ER_OFF  = 22;
  // Status word bit positions.
  localparam int B_RANGE = 31;
  localparam int B_ALIGN = 30;
  localparam int B_BLEN  = 29;
  localparam int B_ESEQ  = 28;
  localparam int B_ESEL  = 27;
  localparam int B_WP    = 26;
  localparam int B_LOCK  = 25;
  localparam int B_LKF   = 24;
  localparam int B_CRC   = 23;
  localparam int B_ILL   = 22;
  localparam int B_ECCF  = 21;
  localparam int B_CC    = 20;
  localparam int B_GEN   = 19;
  localparam int B_UNDR  = 18;
  localparam int B_OVR   = 17;
  localparam int B_IDW   = 16;
  localparam int B_SKIP  = 15;
  localparam int B_ECCD  = 14;
  localparam int B_ERST  = 13;
  localparam int B_STATE = 9;
  localparam int B_RDY   = 8;
  localparam int B_SWF   = 7;
  localparam int B_APP   = 5;
  localparam int B_AUTH  = 3;
  // State codes and field values.
  localparam logic [3:0] ST_IDLE = 4'h0;
  localparam logic [3:0] ST_TRAN = 4'h4;
  localparam logic [1:0] BW_1BIT = 2'b00;
  localparam logic [1:0] BW_4BIT = 2'b10;
  localparam logic [7:0] SPD_MAX = 8'h04;
  localparam logic [7:0] PM_RST  = 8'hff;
  localparam logic [7:0] SPD_RST = 8'h00;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // Extended status frame: start bit, 512 data, 16 CRC, end bit.
  localparam logic [9:0] SDS_BITS  = 10'd512;
  localparam logic [9:0] FRAME_END = 10'd529;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  typedef struct packed {
    logic arg_range_err;
    logic misalign_err;
    logic blk_length_err;
    logic erase_order_err;
    logic erase_select_err;
    logic protect_write_err;
    logic lock_fail_err;
    logic prev_cmd_crc_err;
    logic bad_cmd_err;
    logic ecc_fail_err;
    logic internal_ctrl_err;
    logic general_err;
    logic underrun_err;
    logic overrun_err;
    logic id_reg_write_err;
    logic erase_skip;
    logic erase_reset;
    logic switch_fail_err;
    logic auth_order_err;
    logic expected_a;
  } cst_evt_s;

  typedef struct packed {
    logic locked_flag;
    logic ecc_off;
    logic buf_empty;
    logic stream_mode;
  } cst_live_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } cst_tx_e;
endpackage : cst_pkg

// ===== rtl/cst_card_status.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cst_card_status (
  // System
  input  wire logic               MCLK_IN,
  input  wire logic               RST_N_IN,
  // APB slave
  input  wire logic               PSEL_IN,
  input  wire logic               PENABLE_IN,
  input  wire logic               PWRITE_IN,
  input  wire logic [7:0]         PADDR_IN,
  input  wire logic [31:0]        PWDATA_IN,
  output logic                    PREADY_OUT,
  output logic [31:0]             PRDATA_OUT,
  output logic                    PSLVERR_OUT,
  // Card core
  input  wire cst_pkg::cst_evt_s  EVT_IN,
  input  wire cst_pkg::cst_live_s LIVE_IN,
  input  wire logic [3:0]         STATE_IN,
  input  wire logic               CMD_VALID_IN,
  input  wire logic               RESP_SENT_IN,
  input  wire logic               SDS_REQ_IN,
  output logic [31:0]             STATUS_OUT,
  // Data link
  input  wire logic               SD_CLK_IN,
  output logic                    DAT0_OUT,
  output logic                    DAT0_OE_OUT,
  output logic                    SDS_BUSY_OUT
);
  import cst_pkg::*;

  // ************************************************
  // Event mapping
  // ************************************************
  function automatic logic [31:0] c_set(
    input cst_evt_s e,
    input logic     strm
  );
    logic [31:0] v;
    v = '0;
    v[B_RANGE] = e.arg_range_err;
    v[B_ALIGN] = e.misalign_err;
    v[B_BLEN]  = e.blk_length_err;
    v[B_ESEQ]  = e.erase_order_err;
    v[B_ESEL]  = e.erase_select_err;
    v[B_WP]    = e.protect_write_err;
    v[B_LKF]   = e.lock_fail_err;
    v[B_ECCF]  = e.ecc_fail_err;
    v[B_CC]    = e.internal_ctrl_err;
    v[B_GEN]   = e.general_err;
    v[B_UNDR]  = e.underrun_err & strm;
    v[B_OVR]   = e.overrun_err & strm;
    v[B_IDW]   = e.id_reg_write_err;
    v[B_SKIP]  = e.erase_skip;
    v[B_ERST]  = e.erase_reset;
    v[B_APP]   = e.expected_a;
    v[B_AUTH]  = e.auth_order_err;
    return v;
  endfunction : c_set

  // Serial CRC16, x16+x12+x5+1, zero start value, fed MSB first.
  function automatic logic [15:0] crc_step(
    input logic [15:0] crc,
    input logic        bit_in
  );
    logic fb;
    fb = crc[15] ^ bit_in;
    return {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
  endfunction : crc_step

  // ************************************************
  // Configuration registers
  // ************************************************
  logic [1:0]  bus_width_field_q;
  logic        secured_q;
  logic [7:0]  speed_q;
  logic [7:0]  perf_q;
  logic [3:0]  au_q;
  logic [31:0] protected_span_q;
  logic [15:0] erase_size_q;
  logic [5:0]  erase_to_q;
  logic [1:0]  erase_off_q;
  logic [15:0] card_variant_q;
  logic        wr_en;
  logic        rd_en;
  logic        map_hit;

  // A write commits at the edge where the master sees ready high, so the
  // register changes together with the completion of the transfer.
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
  assign rd_en = PSEL_IN & PENABLE_IN & ~PWRITE_IN & ~PREADY_OUT;

  always_comb begin
    case (PADDR_IN)
      REG_CFG,
      REG_SPAN,
      REG_ERASE,
      REG_VAR,
      REG_STAT,
      REG_LIVE: map_hit = 1'b1;
      default:  map_hit = 1'b0;
    endcase
  end

  // Reserved width and speed codes are refused so the block never
  // advertises a value the host cannot interpret.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bus_width_field_q <= BW_1BIT;
      secured_q         <= 1'b0;
      speed_q           <= SPD_RST;
      perf_q            <= PM_RST;
      au_q              <= 4'h0;
    end else if (wr_en && PADDR_IN == REG_CFG) begin
      if (PWDATA_IN[1:0] == BW_1BIT || PWDATA_IN[1:0] == BW_4BIT) begin
        bus_width_field_q <= PWDATA_IN[1:0];
      end
      secured_q <= PWDATA_IN[CFG_SEC];
      if (PWDATA_IN[CFG_SPD+:8] <= SPD_MAX) begin
        speed_q <= PWDATA_IN[CFG_SPD+:8];
      end
      perf_q <= PWDATA_IN[CFG_PM+:8];
      au_q   <= PWDATA_IN[CFG_AU+:4];
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      protected_span_q <= REG_RST;
      erase_size_q     <= 16'h0000;
      erase_to_q       <= 6'h00;
      erase_off_q      <= 2'b00;
      card_variant_q   <= 16'h0000;
    end else if (wr_en) begin
      case (PADDR_IN)
        REG_SPAN: begin
          protected_span_q <= PWDATA_IN;
        end
        REG_ERASE: begin
          erase_size_q <= PWDATA_IN[15:0];
          erase_to_q   <= PWDATA_IN[ER_TO+:6];
          erase_off_q  <= PWDATA_IN[ER_OFF+:2];
        end
        REG_VAR: begin
          card_variant_q <= PWDATA_IN[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************
  // Card status word
  // ************************************************
  localparam logic [31:0] C_MASK = 32'hfdff_a028;
  localparam logic [31:0] B_MASK = 32'h00c0_0080;

  logic [31:0] c_q;
  logic [31:0] b_acc_q;
  logic [31:0] b_rep_q;
  logic [3:0]  state_q;
  logic [31:0] cset;
  logic [31:0] bset;
  logic [31:0] c_clr;
  logic [31:0] a_bits;
  logic        sds_refuse;

  assign cset = c_set(EVT_IN, LIVE_IN.stream_mode);

  always_comb begin
    bset        = '0;
    bset[B_CRC] = EVT_IN.prev_cmd_crc_err;
    bset[B_ILL] = EVT_IN.bad_cmd_err | sds_refuse;
    bset[B_SWF] = EVT_IN.switch_fail_err;
  end

  // Only bits that actually went out in the sent word are cleared, so an
  // error raised between snapshot and send still reaches the host.
  assign c_clr = RESP_SENT_IN ? (STATUS_OUT & C_MASK) : '0;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      c_q <= '0;
    end else begin
      c_q <= (c_q & ~c_clr) | cset;
    end
  end

  // Previous-command bits collect until a valid command, then stand in
  // every response until the next valid command replaces them.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      b_acc_q <= '0;
      b_rep_q <= '0;
    end else if (CMD_VALID_IN) begin
      b_rep_q <= (b_acc_q | bset) & B_MASK;
      b_acc_q <= '0;
    end else begin
      b_acc_q <= b_acc_q | bset;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
    end else if (CMD_VALID_IN) begin
      state_q <= STATE_IN;
    end
  end

  always_comb begin
    a_bits         = '0;
    a_bits[B_LOCK] = LIVE_IN.locked_flag;
    a_bits[B_ECCD] = LIVE_IN.ecc_off;
    a_bits[B_RDY]  = LIVE_IN.buf_empty;
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      STATUS_OUT <= '0;
    end else begin
      STATUS_OUT <= (c_q & C_MASK) | b_rep_q | a_bits
                  | {19'h0, state_q, 9'h000};
    end
  end

  // ************************************************
  // Link clock sampling
  // ************************************************
  logic clk_s1_q;
  logic clk_s2_q;
  // The third stage only holds the old level for edge detection.
  logic clk_s3_q;
  logic link_fall;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end else begin
      clk_s1_q <= SD_CLK_IN;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  // Data changes after the falling edge so the host can sample it at the next fall.
  assign link_fall = clk_s3_q & ~clk_s2_q;

  // ************************************************
  // Extended status transmitter
  // ************************************************
  cst_tx_e      tx_q;
  logic [511:0] sds_sr_q;
  logic [15:0]  crc_q;
  logic [9:0]   cnt_q;
  logic [511:0] sds_word;

  assign sds_word = {bus_width_field_q, secured_q, 13'h0000,
                     card_variant_q, protected_span_q,
                     speed_q, perf_q, au_q, 4'h0,
                     erase_size_q, erase_to_q, erase_off_q,
                     400'h0};

  // A limitation: if the host halts its clock mid-frame, the transmitter
  // simply waits; only a reset abandons a partly sent block.
  // A request outside transfer state, or while a block is still going
  // out, is refused and reported as an bad_cmd_err.
  assign sds_refuse = SDS_REQ_IN & (STATE_IN != ST_TRAN || tx_q != TX_IDLE);

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_q         <= TX_IDLE;
      sds_sr_q     <= '0;
      crc_q        <= 16'h0000;
      cnt_q        <= 10'd0;
      DAT0_OUT     <= 1'b1;
      DAT0_OE_OUT  <= 1'b0;
      SDS_BUSY_OUT <= 1'b0;
    end else begin
      case (tx_q)
        TX_IDLE: begin
          if (SDS_REQ_IN && !sds_refuse) begin
            sds_sr_q     <= sds_word;
            crc_q        <= 16'h0000;
            cnt_q        <= 10'd0;
            SDS_BUSY_OUT <= 1'b1;
            tx_q         <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (link_fall) begin
            DAT0_OUT    <= 1'b0;
            DAT0_OE_OUT <= 1'b1;
            tx_q        <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (link_fall) begin
            cnt_q <= cnt_q + 10'd1;
            if (cnt_q < SDS_BITS) begin
              DAT0_OUT <= sds_sr_q[511];
              crc_q    <= crc_step(crc_q, sds_sr_q[511]);
              sds_sr_q <= {sds_sr_q[510:0], 1'b0};
            end else if (cnt_q < FRAME_END - 10'd1) begin
              DAT0_OUT <= crc_q[15];
              crc_q    <= {crc_q[14:0], 1'b0};
            end else if (cnt_q == FRAME_END - 10'd1) begin
              DAT0_OUT <= 1'b1;
            end else begin
              DAT0_OE_OUT  <= 1'b0;
              SDS_BUSY_OUT <= 1'b0;
              tx_q         <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // APB answer
  // ************************************************
  // One wait state: the answer is registered so every bus output is a flop.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~map_hit;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= '0;
    end else if (rd_en) begin
      case (PADDR_IN)
        REG_CFG: begin
          PRDATA_OUT <= {4'h0, au_q, perf_q, speed_q, 5'h00,
                         secured_q, bus_width_field_q};
        end
        REG_SPAN: begin
          PRDATA_OUT <= protected_span_q;
        end
        REG_ERASE: begin
          PRDATA_OUT <= {8'h00, erase_off_q, erase_to_q, erase_size_q};
        end
        REG_VAR: begin
          PRDATA_OUT <= {16'h0000, card_variant_q};
        end
        REG_STAT: begin
          PRDATA_OUT <= STATUS_OUT;
        end
        REG_LIVE: begin
          PRDATA_OUT <= {21'h0, cnt_q, SDS_BUSY_OUT};
        end
        default: begin
          PRDATA_OUT <= '0;
        end
      endcase
    end else begin
      PRDATA_OUT <= '0;
    end
  end
endmodule : cst_card_status
`default_nettype wire

// ===== testbench/cst_card_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cst_status_chk (
  // Clock and reset
  input wire logic               MCLK_IN,
  input wire logic               RST_N_IN,
  // Card core
  input wire cst_pkg::cst_evt_s  EVT_IN,
  input wire cst_pkg::cst_live_s LIVE_IN,
  input wire logic [3:0]         STATE_IN,
  input wire logic               CMD_VALID_IN,
  input wire logic               RESP_SENT_IN,
  input wire logic               SDS_REQ_IN,
  input wire logic [31:0]        STATUS_OUT,
  // Data link
  input wire logic               DAT0_OE_OUT,
  input wire logic               SDS_BUSY_OUT
);
  import cst_pkg::*;
  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_range;
    EVT_IN.arg_range_err |-> ##2 STATUS_OUT[B_RANGE];
  endproperty
  a_range: assert property (p_range) else $error("range flag late");
  property p_align;
    EVT_IN.misalign_err |-> ##2 STATUS_OUT[B_ALIGN];
  endproperty
  a_align: assert property (p_align) else $error("align flag late");
  property p_clr;
    RESP_SENT_IN && STATUS_OUT[B_BLEN] && !EVT_IN.blk_length_err |-> ##2 !STATUS_OUT[B_BLEN];
  endproperty
  a_clr: assert property (p_clr) else $error("length flag kept");
  property p_live;
    $past(RST_N_IN, 2) |-> STATUS_OUT[B_LOCK] == $past(LIVE_IN.locked_flag)
      && STATUS_OUT[B_ECCD] == $past(LIVE_IN.ecc_off);
  endproperty
  a_live: assert property (p_live) else $error("live bits wrong");
  property p_rdy;
    $past(RST_N_IN, 2) |-> STATUS_OUT[B_RDY] == $past(LIVE_IN.buf_empty);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready bit wrong");
  property p_rsvd;
    {STATUS_OUT[6], STATUS_OUT[4], STATUS_OUT[2:0]} == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_state;
    $past(RST_N_IN, 2) && !$past(CMD_VALID_IN) && !$past(CMD_VALID_IN, 2)
      |-> $stable(STATUS_OUT[12:9]);
  endproperty
  a_state: assert property (p_state) else $error("state moved");
  property p_strm;
    $rose(STATUS_OUT[B_UNDR]) |-> $past(LIVE_IN.stream_mode, 2);
  endproperty
  a_strm: assert property (p_strm) else $error("underrun off mode");
  property p_take;
    SDS_REQ_IN && STATE_IN == ST_TRAN && !SDS_BUSY_OUT |=> SDS_BUSY_OUT;
  endproperty
  a_take: assert property (p_take) else $error("request lost");
  property p_refuse;
    SDS_REQ_IN && STATE_IN != ST_TRAN && !SDS_BUSY_OUT |=> !SDS_BUSY_OUT;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request taken");
  property p_oe;
    !SDS_BUSY_OUT |-> !DAT0_OE_OUT;
  endproperty
  a_oe: assert property (p_oe) else $error("line driven idle");
endmodule : cst_status_chk

bind cst_card_status cst_status_chk u_chk (.MCLK_IN, .RST_N_IN, .EVT_IN, .LIVE_IN,
  .STATE_IN, .CMD_VALID_IN, .RESP_SENT_IN, .SDS_REQ_IN, .STATUS_OUT, .DAT0_OE_OUT,
  .SDS_BUSY_OUT);
`default_nettype wire

// ===== testbench/cst_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cst_host_model (
  // Control
  input  wire logic          run_in,
  // Link
  output logic               sd_clk_out,
  input  wire logic          dat0_in,
  input  wire logic          dat0_oe_in,
  // Captured frame
  output logic [529:0]       frame_out,
  output int                 nbits_out
);
  int n = 0;
  // ****************
  // Link clock
  // ****************
  // The clock only runs inside a frame and stands still low between them.
  initial begin
    sd_clk_out = 1'b0;
    #37;
    forever begin
      #160;
      sd_clk_out = run_in ? ~sd_clk_out : 1'b0;
    end
  end
  // Sampling just before the next fall keeps clear of the card's sync delay.
  always @(negedge sd_clk_out) begin
    if (dat0_oe_in) begin
      frame_out <= {frame_out[528:0], dat0_in};
      n <= n + 1;
    end
  end
  assign nbits_out = n;
endmodule : cst_host_model
`default_nettype wire

// ===== testbench/tb_card_status_reporting.sv
`timescale 1ns/1ps
`default_nettype none
module tb_card_status_reporting;
  import cst_pkg::*;
  logic         clk, rst_n, psel, pen, pwr, pready, pslverr, cmd, resp, sreq;
  logic         dat0, oe, busy, run, sdclk, err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, stat, rd;
  logic [3:0]   state;
  logic [529:0] frame;
  logic [511:0] sds;
  logic [15:0]  crc;
  cst_evt_s     evt;
  cst_live_s    live;
  int           nbits;
  int           fail_count = 0;
  int           n_compared = 0;
  int           ei[17] = '{19, 18, 17, 16, 15, 14, 13, 10, 9, 8, 7, 6, 5, 4, 3, 1, 0};
  int           sb[17] = '{31, 30, 29, 28, 27, 26, 24, 21, 20, 19, 18, 17, 16, 15, 13, 3, 5};

  cst_card_status u_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .EVT_IN(evt), .LIVE_IN(live),
    .STATE_IN(state), .CMD_VALID_IN(cmd), .RESP_SENT_IN(resp), .SDS_REQ_IN(sreq),
    .STATUS_OUT(stat), .SD_CLK_IN(sdclk), .DAT0_OUT(dat0), .DAT0_OE_OUT(oe),
    .SDS_BUSY_OUT(busy));
  cst_host_model u_host (.run_in(run), .sd_clk_out(sdclk), .dat0_in(dat0),
    .dat0_oe_in(oe), .frame_out(frame), .nbits_out(nbits));

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // The request is held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic evp(input logic [19:0] v, input logic c, input logic r, input logic s);
    @(posedge clk);
    evt <= v;
    cmd <= c;
    resp <= r;
    sreq <= s;
    @(posedge clk);
    evt <= '0;
    cmd <= 1'b0;
    resp <= 1'b0;
    sreq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : evp

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #1_000_000;
    fail_count++;
    summarize();
  end

  // ****************
  // Tests
  // ****************
  initial begin
    {rst_n, psel, pen, pwr, cmd, resp, sreq, run} = '0;
    {paddr, pwdata, state, evt, live} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    apb(0, REG_STAT, 0);
    chk(rd, 32'h0);
    apb(0, 8'h18, 0);
    chk({rd[30:0], err}, 32'h1);
    apb(0, REG_CFG, 0);
    chk(rd, 32'h00ff_0000);
    live <= 4'h1;
    for (int i = 0; i < 17; i++) begin
      evp(20'h1 << ei[i], 0, 0, 0);
      chk(stat, 32'h1 << sb[i]);
      evp(0, 0, 1, 0);
      chk(stat, 32'h0);
    end
    live <= 4'h0;
    evp(20'h000c0, 0, 0, 0);
    chk(stat, 32'h0);
    state <= 4'h3;
    evp(20'h01804, 0, 0, 0);
    chk(stat, 32'h0);
    evp(0, 1, 0, 0);
    chk(stat, 32'h00c0_0680);
    state <= 4'h4;
    evp(0, 0, 1, 0);
    chk(stat, 32'h00c0_0680);
    evp(0, 1, 0, 0);
    chk(stat, 32'h0000_0800);
    live <= 4'he;
    repeat (3) @(posedge clk);
    chk(stat, 32'h0200_4900);
    apb(0, REG_STAT, 0);
    chk(rd, 32'h0200_4900);
    apb(1, REG_CFG, 32'h0920_0406);
    apb(1, REG_CFG, 32'h0920_0505);
    apb(0, REG_CFG, 0);
    chk(rd, 32'h0920_0406);
    apb(1, REG_SPAN, 32'h1234_5678);
    apb(1, REG_ERASE, 32'h00c5_0010);
    apb(1, REG_VAR, 32'h0000_0001);
    state <= 4'h3;
    evp(0, 0, 0, 1);
    chk({31'h0, busy}, 32'h0);
    evp(0, 1, 0, 0);
    chk({31'h0, stat[22]}, 32'h1);
    state <= 4'h4;
    evp(0, 0, 0, 1);
    chk({31'h0, busy}, 32'h1);
    apb(0, REG_LIVE, 0);
    chk(rd, 32'h0000_0001);
    run <= 1'b1;
    for (int n = 0; n < 10000 && busy !== 1'b0; n++) @(posedge clk);
    run <= 1'b0;
    chk({31'h0, busy}, 32'h0);
    sds = '0;
    sds[511:509] = 3'b101;
    sds[495:480] = 16'h0001;
    sds[479:448] = 32'h1234_5678;
    sds[447:428] = 20'h0420_9;
    sds[423:400] = 24'h0010_17;
    crc = '0;
    for (int i = 511; i >= 0; i--) begin
      crc = {crc[14:0], 1'b0} ^ (((crc[15] ^ sds[i]) == 1'b1) ? CRC_POLY : 16'h0);
    end
    chk(32'(nbits), 32'd530);
    chk({30'h0, frame[529], frame[0]}, 32'h1);
    for (int k = 0; k < 16; k++) begin
      chk(frame[17 + 32 * k +: 32], sds[32 * k +: 32]);
    end
    chk({16'h0, frame[16:1]}, {16'h0, crc});
    summarize();
  end
endmodule : tb_card_status_reporting
`default_nettype wire
